/* File: pgf_defines.svh */
/*
  Constants for the pulse, gear, filter and encoder monitor block.
  Assumes a 100 MHz sys_clk; included by bare name.
*/
`ifndef PGF_DEFINES_SVH
`define PGF_DEFINES_SVH
`define PGF_CLK_HZ 100_000_000
`define PGF_NS_PER_S 1_000_000_000
`define PGF_CMD_UNITS_PER_REV 32768
`define PGF_SERIAL_DIV 32768
`define PGF_INC_M_DIV 8192
`define PGF_GEAR_MIN_DIV 20
`define PGF_GEAR_MAX_MUL 50
`define PGF_SER_MUL_MIN 16
`define PGF_SER_MUL_MAX 8192
`define PGF_INC_N_MAX 64
`define PGF_INC_N2_MIN 3
`define PGF_INC_M_MAX 8191
`define PGF_FILT_TICK_NS 1_000_000
`define PGF_TICK_CYC (`PGF_FILT_TICK_NS / (`PGF_NS_PER_S / `PGF_CLK_HZ))
`define PGF_MON_BLANK_S 3
`define PGF_MON_BLANK_CYC (`PGF_MON_BLANK_S * `PGF_CLK_HZ)
`define PGF_Z_STEPS 2
`define PGF_REG_CTRL 8'h00
`define PGF_REG_HALF 8'h04
`define PGF_REG_MOVE 8'h08
`define PGF_REG_STAT 8'h0c
`define PGF_REG_MPOS 8'h10
`define PGF_REG_ZCNT 8'h14
`define PGF_CTRL_EN 0
`define PGF_CTRL_SEL 1
`define PGF_CTRL_ISO 2
`define PGF_CTRL_QUAD 3
`define PGF_HALF_RESET 16'h0032
`endif

/* File: pgf_pkg.sv */
/*
  Types and quadrature helpers shared by both ends.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pgf_pkg;
  typedef enum logic [2:0] {
    PGF_PM_PS = 3'b000,
    PGF_PM_FR = 3'b001,
    PGF_PM_AB = 3'b010,
    PGF_PM_NPS = 3'b011,
    PGF_PM_RF = 3'b100,
    PGF_PM_BA = 3'b101
  } pgf_pmode_e;
  typedef enum logic {
    PGF_ENC_SERIAL = 1'b0,
    PGF_ENC_INC = 1'b1
  } pgf_enc_e;
  typedef logic signed [1:0] pgf_step_t;
  // gray position 0..3 of an a/b pair, a leading b going up
  function automatic logic [1:0] quad_idx(input logic a, input logic b);
    return {b, a ^ b};
  endfunction
  // one quadrature edge to +1/-1; a double jump is dropped
  function automatic pgf_step_t quad_step(input logic [1:0] o,
                                          input logic [1:0] n);
    logic [1:0] d;
    d = n - o;
    case (d)
      2'b01: return 2'sb01;
      2'b11: return 2'sb11;
      default: return 2'sb00;
    endcase
  endfunction
endpackage

/* File: pgf_if.sv */
/*
  Link between the motion host and the drive: command pin pairs,
  enable/select pins and the monitor outputs. Pins are plain levels;
  a pair carries current pos to neg when pos is high and neg low.
*/
`timescale 1ns/1ps
`default_nettype none
interface pgf_if;
  logic cmd_pulse_pos_pin;
  logic cmd_pulse_neg_pin;
  logic cmd_dir_pos_pin;
  logic cmd_dir_neg_pin;
  logic pulse_count_enable;
  logic gear_ratio_select;
  logic mon_a_pos_pin;
  logic mon_a_neg_pin;
  logic mon_b_pos_pin;
  logic mon_b_neg_pin;
  logic mon_z_pos_pin;
  logic mon_z_neg_pin;
  logic monitor_phase_z_out;
  modport device (
    input cmd_pulse_pos_pin, cmd_pulse_neg_pin, cmd_dir_pos_pin,
    input cmd_dir_neg_pin, pulse_count_enable, gear_ratio_select,
    output mon_a_pos_pin, mon_a_neg_pin, mon_b_pos_pin, mon_b_neg_pin,
    output mon_z_pos_pin, mon_z_neg_pin, monitor_phase_z_out
  );
  modport host (
    output cmd_pulse_pos_pin, cmd_pulse_neg_pin, cmd_dir_pos_pin,
    output cmd_dir_neg_pin, pulse_count_enable, gear_ratio_select,
    input mon_a_pos_pin, mon_a_neg_pin, mon_b_pos_pin, mon_b_neg_pin,
    input mon_z_pos_pin, mon_z_neg_pin, monitor_phase_z_out
  );
endinterface
`default_nettype wire

/* File: pgf_filter.sv */
/*
  First-order smoothing filter, stepped once per tick.
  Assumes tick is a one-cycle pulse of the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module pgf_filter #(
  parameter int W = 32,
  parameter int TC_W = 16
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic bypass,
  input wire logic [TC_W-1:0] tc,
  input wire logic signed [W-1:0] x_in,
  output logic signed [W-1:0] y_out
);
  import pgf_pkg::*;
  typedef struct packed {
    logic signed [W-1:0] y;
  } pgf_filt_s;
  pgf_filt_s s_q;
  pgf_filt_s s_d;
  logic signed [W:0] diff;
  if (W < 2 || TC_W < 1 || TC_W >= W) begin : g_bad
    $error("pgf_filter: unsupported widths");
  end
  // y moves 1/tc of the gap per ms; gaps under tc units stay put
  always_comb
  begin
    s_d = s_q;
    diff = (W+1)'(x_in) - (W+1)'(s_q.y);
    if (bypass || tc == '0)
    begin
      s_d.y = x_in;
    end
    else if (tick)
    begin
      s_d.y = s_q.y + W'(diff / $signed({1'b0, tc}));
    end
  end
  // state register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign y_out = s_q.y;
endmodule // pgf_filter
`default_nettype wire

/* File: pgf_device.sv */
/*
  Drive end: command pulse counting, electronic gear, command
  smoothing filters and the divided encoder monitor.
  Assumes enc_a/enc_b/enc_z and settings come from logic on sys_clk;
  link pins are asynchronous and are synchronised here.
*/
// What this block does
// - count a pulse on its rising edge
// - current direction decodes per isolation type
// - gear ratio A when select off, else B
// - one revolution is 32768 command units
// - gear terms 1..65535, ratio 1/20..50
// - speed filter always on, 0 bypasses
// - position filter only in position mode
// - host zeroes position filter for endless runs
// - Z passes undivided, A/B divided
// - serial: M/32768, M from 16 to 8192
// - bad monitor setting: outputs off, fault
// - serial Z as wide as one A pulse
// - A leads B forward, order setting swaps
// - divisor used only with incremental encoder
// - monitor settings taken once after reset
// - monitor invalid for 3 s after power-on
// - logic 1 drives pos to neg, Z on
// - count only in position mode, enabled
// - quadrature modes count every edge
`timescale 1ns/1ps
`default_nettype none
`include "pgf_defines.svh"
module pgf_device #(
  parameter int PW = 32,
  parameter int TC_W = 16,
  parameter int TICK_CYCLES = `PGF_TICK_CYC,
  parameter int BLANK_CYCLES = `PGF_MON_BLANK_CYC
) (
  pgf_if.device link,
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic position_mode,
  input wire logic isolated_logic,
  input wire pgf_pkg::pgf_pmode_e pulse_mode,
  input wire logic [15:0] gear_num_a,
  input wire logic [15:0] gear_den_a,
  input wire logic [15:0] gear_num_b,
  input wire logic [15:0] gear_den_b,
  input wire logic [TC_W-1:0] speed_filter_tc,
  input wire logic [TC_W-1:0] position_filter_tc,
  input wire logic signed [PW-1:0] speed_cmd_in,
  input wire logic enc_a,
  input wire logic enc_b,
  input wire logic enc_z,
  input wire pgf_pkg::pgf_enc_e encoder_type_select,
  input wire logic [13:0] monitor_multiplier,
  input wire logic [13:0] monitor_divisor,
  input wire logic monitor_phase_order,
  output logic signed [PW-1:0] position_cmd,
  output logic signed [PW-1:0] position_cmd_filt,
  output logic signed [PW-1:0] speed_cmd_filt,
  output logic gear_ratio_fault,
  output logic monitor_setting_fault,
  output logic monitor_valid
);
  import pgf_pkg::*;
  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int BW = $clog2(BLANK_CYCLES + 1);
  typedef struct packed {
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic [1:0] ctl_s1;
    logic [1:0] ctl_s2;
    logic pls_q;
    logic dir_q;
    logic sel_q;
    logic signed [19:0] res;
    logic signed [PW-1:0] pos;
    logic cfg_done;
    logic [13:0] mul;
    logic [13:0] div;
    logic order;
    pgf_enc_e enc;
    logic fault;
    logic [1:0] enc_idx;
    logic enc_z_q;
    logic signed [17:0] acc;
    logic [1:0] mon_idx;
    logic z_hold;
    logic [1:0] z_steps;
    logic [BW-1:0] blank;
    logic valid;
    logic [TW-1:0] tick_cnt;
    logic tick;
    logic [6:0] pins;
  } pgf_dev_s;
  pgf_dev_s s_q;
  pgf_dev_s s_d;
  logic cmd_pulse_in;
  logic dir;
  logic sel;
  logic [15:0] num;
  logic [15:0] den;
  pgf_step_t step;
  pgf_step_t estep;
  pgf_step_t mstep;
  logic [1:0] eidx;
  logic signed [19:0] res_in;
  logic signed [19:0] sum;
  logic signed [17:0] acc_n;
  logic signed [17:0] mdiv;
  logic av;
  logic bv;
  logic zv;
  logic on;
  if (PW < 20 || TC_W < 1 || TC_W >= PW || TICK_CYCLES < 1 ||
      BLANK_CYCLES < 1) begin : g_bad
    $error("pgf_device: unsupported parameters");
  end
  // pair to logic level; no current in either way reads as 0
  function automatic logic pair_level(input logic p, input logic n,
                                      input logic iso);
    return iso ? (p & ~n) : (n & ~p);
  endfunction
  // gear terms in range and 1/20 <= num/den <= 50
  function automatic logic ratio_ok(input logic [15:0] n,
                                    input logic [15:0] d);
    return n != '0 && d != '0 &&
      (24'(n) * 24'(`PGF_GEAR_MIN_DIV) >= 24'(d)) &&
      (24'(n) <= 24'(d) * 24'(`PGF_GEAR_MAX_MUL));
  endfunction
  // legal monitor setting for the fitted encoder
  function automatic logic mon_ok(input pgf_enc_e e, input logic [13:0] m,
                                  input logic [13:0] d);
    if (e == PGF_ENC_SERIAL)
      return m >= 14'(`PGF_SER_MUL_MIN) && m <= 14'(`PGF_SER_MUL_MAX);
    else if (d == 14'(`PGF_INC_M_DIV))
      return m != '0 && m <= 14'(`PGF_INC_M_MAX);
    else if (m == 14'h0001)
      return d != '0 && d <= 14'(`PGF_INC_N_MAX);
    else if (m == 14'h0002)
      return d >= 14'(`PGF_INC_N2_MIN) && d <= 14'(`PGF_INC_N_MAX);
    else
      return 1'b0;
  endfunction
  // whole next-state computation
  always_comb
  begin
    s_d = s_q;
    step = '0;
    estep = '0;
    mstep = '0;
    res_in = s_q.res;
    sum = '0;
    acc_n = s_q.acc;
    // link pins pass two flops before any decode
    s_d.pin_s1 = {link.cmd_pulse_pos_pin, link.cmd_pulse_neg_pin,
                  link.cmd_dir_pos_pin, link.cmd_dir_neg_pin};
    s_d.pin_s2 = s_q.pin_s1;
    s_d.ctl_s1 = {link.pulse_count_enable, link.gear_ratio_select};
    s_d.ctl_s2 = s_q.ctl_s1;
    cmd_pulse_in = pair_level(s_q.pin_s2[3], s_q.pin_s2[2], isolated_logic);
    dir = pair_level(s_q.pin_s2[1], s_q.pin_s2[0], isolated_logic);
    s_d.pls_q = cmd_pulse_in;
    s_d.dir_q = dir;
    if (position_mode && s_q.ctl_s2[1])
    begin
      case (pulse_mode)
        // rising edge counts, sig gives sign
        PGF_PM_PS: step = (cmd_pulse_in & ~s_q.pls_q) ? (dir ? 2'sb01 : 2'sb11) : '0;
        PGF_PM_NPS: step = (cmd_pulse_in & ~s_q.pls_q) ? (dir ? 2'sb11 : 2'sb01) : '0;
        PGF_PM_FR: step = $signed({1'b0, cmd_pulse_in & ~s_q.pls_q}) -
                          $signed({1'b0, dir & ~s_q.dir_q});
        PGF_PM_RF: step = $signed({1'b0, dir & ~s_q.dir_q}) -
                          $signed({1'b0, cmd_pulse_in & ~s_q.pls_q});
        PGF_PM_AB: step = quad_step(quad_idx(s_q.pls_q, s_q.dir_q),
                                    quad_idx(cmd_pulse_in, dir));
        PGF_PM_BA: step = quad_step(quad_idx(s_q.dir_q, s_q.pls_q),
                                    quad_idx(dir, cmd_pulse_in));
        default: step = '0;
      endcase
    end
    // ratio chosen by the select pin
    sel = s_q.ctl_s2[0];
    num = sel ? gear_num_b : gear_num_a;
    den = sel ? gear_den_b : gear_den_a;
    if (step != '0 && ratio_ok(num, den))
    begin
      // new ratio starts clean at this pulse
      if (sel != s_q.sel_q)
      begin
        res_in = '0;
      end
      s_d.sel_q = sel;
      // remainder carried, sign follows the sum
      sum = res_in + step * $signed({4'h0, num});
      s_d.res = sum % $signed({4'h0, den});
      s_d.pos = s_q.pos + PW'(sum / $signed({4'h0, den}));
    end
    // filter time base, 1 ms
    s_d.tick = s_q.tick_cnt == TW'(TICK_CYCLES - 1);
    s_d.tick_cnt = s_d.tick ? '0 : s_q.tick_cnt + 1'b1;
    // settings frozen at the first edge after reset
    if (!s_q.cfg_done)
    begin
      s_d.cfg_done = 1'b1;
      s_d.mul = monitor_multiplier;
      s_d.div = monitor_divisor;
      s_d.order = monitor_phase_order;
      s_d.enc = encoder_type_select;
      // bad combination latched as a fault
      s_d.fault = !mon_ok(encoder_type_select, monitor_multiplier,
                          monitor_divisor);
    end
    if (s_q.blank != BW'(BLANK_CYCLES))
    begin
      s_d.blank = s_q.blank + 1'b1;
    end
    s_d.valid = s_q.blank == BW'(BLANK_CYCLES);
    eidx = quad_idx(enc_a, enc_b);
    estep = quad_step(s_q.enc_idx, eidx);
    s_d.enc_idx = eidx;
    mdiv = (s_q.enc == PGF_ENC_SERIAL) ? 18'(`PGF_SERIAL_DIV) :
           18'(s_q.div);
    // rate mul/mdiv; mul <= mdiv so one step at most
    if (s_q.cfg_done && !s_q.fault)
    begin
      acc_n = s_q.acc + estep * $signed({4'h0, s_q.mul});
      if (acc_n >= mdiv)
      begin
        acc_n = acc_n - mdiv;
        mstep = 2'sb01;
      end
      else if (acc_n <= -mdiv)
      begin
        acc_n = acc_n + mdiv;
        mstep = 2'sb11;
      end
    end
    s_d.acc = acc_n;
    s_d.mon_idx = s_q.mon_idx + 2'(mstep);
    // serial Z held for one divided A/B pulse
    s_d.enc_z_q = enc_z;
    if (enc_z & ~s_q.enc_z_q)
    begin
      s_d.z_hold = 1'b1;
      s_d.z_steps = '0;
    end
    else if (s_q.z_hold && mstep != '0)
    begin
      if (s_q.z_steps == 2'(`PGF_Z_STEPS - 1))
      begin
        s_d.z_hold = 1'b0;
      end
      s_d.z_steps = s_q.z_steps + 1'b1;
    end
    // a leads b forward unless swapped
    av = s_q.mon_idx[0] ^ s_q.mon_idx[1];
    bv = s_q.mon_idx[1];
    if (s_q.order)
    begin
      av = s_q.mon_idx[1];
      bv = s_q.mon_idx[0] ^ s_q.mon_idx[1];
    end
    // Z undivided; incremental Z passes straight
    zv = (s_q.enc == PGF_ENC_SERIAL) ? s_q.z_hold : enc_z;
    // outputs dark while invalid or faulted
    on = s_q.valid & s_q.cfg_done & ~s_q.fault;
    // level 1 drives pos to neg, Z transistor on
    s_d.pins = {on & av, on & ~av, on & bv, on & ~bv,
                on & zv, on & ~zv, on & zv};
  end
  // state register
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // speed command always through its filter
  pgf_filter #(.W(PW), .TC_W(TC_W)) u_speed_filt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(s_q.tick),
    .bypass(1'b0),
    .tc(speed_filter_tc),
    .x_in(speed_cmd_in),
    .y_out(speed_cmd_filt)
  );
  // position filter bypassed outside position mode
  pgf_filter #(.W(PW), .TC_W(TC_W)) u_pos_filt (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .tick(s_q.tick),
    .bypass(!position_mode),
    .tc(position_filter_tc),
    .x_in(s_q.pos),
    .y_out(position_cmd_filt)
  );
  assign position_cmd = s_q.pos;
  assign gear_ratio_fault = !ratio_ok(s_q.ctl_s2[0] ? gear_num_b : gear_num_a,
                                      s_q.ctl_s2[0] ? gear_den_b : gear_den_a);
  assign monitor_setting_fault = s_q.fault;
  assign monitor_valid = s_q.valid & s_q.cfg_done & ~s_q.fault;
  assign link.mon_a_pos_pin = s_q.pins[6];
  assign link.mon_a_neg_pin = s_q.pins[5];
  assign link.mon_b_pos_pin = s_q.pins[4];
  assign link.mon_b_neg_pin = s_q.pins[3];
  assign link.mon_z_pos_pin = s_q.pins[2];
  assign link.mon_z_neg_pin = s_q.pins[1];
  assign link.monitor_phase_z_out = s_q.pins[0];
endmodule // pgf_device
`default_nettype wire

/* File: pgf_host.sv */
/*
  Motion host end: emits command pulse trains and counts the monitor
  outputs. Software reaches it over a plain strobe port; read data
  stand the cycle after the read strobe. Monitor pins are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pgf_defines.svh"
module pgf_host #(
  parameter int BLANK_CYCLES = `PGF_MON_BLANK_CYC
) (
  pgf_if.host link,
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata
);
  import pgf_pkg::*;
  localparam int BW = $clog2(BLANK_CYCLES + 1);
  typedef struct packed {
    logic [3:0] ctrl;
    logic [15:0] half;
    logic signed [31:0] remain;
    logic [15:0] tmr;
    logic cmd_pulse_in;
    logic [1:0] qidx;
    logic dir;
    logic [3:0] pins;
    logic [31:0] rdata;
    logic [2:0] s1;
    logic [2:0] s2;
    logic [1:0] midx;
    logic zq;
    logic signed [31:0] mpos;
    logic [15:0] zcnt;
    logic [BW-1:0] wait_cnt;
    logic ready;
  } pgf_host_s;
  pgf_host_s s_q;
  pgf_host_s s_d;
  logic pv;
  logic dv;
  logic quad;
  if (BLANK_CYCLES < 1) begin : g_bad
    $error("pgf_host: BLANK_CYCLES must be positive");
  end
  // registers, pulse generator and monitor counter
  always_comb
  begin
    s_d = s_q;
    quad = s_q.ctrl[`PGF_CTRL_QUAD];
    if (wr && addr == `PGF_REG_CTRL)
      s_d.ctrl = wdata[3:0];
    if (wr && addr == `PGF_REG_HALF)
      s_d.half = wdata[15:0];
    // a move write restarts the train with its own sign
    if (wr && addr == `PGF_REG_MOVE)
    begin
      s_d.remain = $signed(wdata);
      s_d.dir = !wdata[31];
      s_d.tmr = '0;
    end
    else if (s_q.remain != '0)
    begin
      if (s_q.tmr != '0)
        s_d.tmr = s_q.tmr - 1'b1;
      else
      begin
        s_d.tmr = s_q.half;
        if (quad)
        begin
          s_d.qidx = s_q.dir ? s_q.qidx + 1'b1 : s_q.qidx - 1'b1;
          s_d.remain = s_q.dir ? s_q.remain - 1 : s_q.remain + 1;
        end
        else
        begin
          s_d.cmd_pulse_in = !s_q.cmd_pulse_in;
          if (s_q.cmd_pulse_in)
            s_d.remain = s_q.dir ? s_q.remain - 1 : s_q.remain + 1;
        end
      end
    end
    // level 1 is neg to pos unless isolated
    pv = quad ? (s_q.qidx[0] ^ s_q.qidx[1]) : s_q.cmd_pulse_in;
    dv = quad ? s_q.qidx[1] : s_q.dir;
    if (!s_q.ctrl[`PGF_CTRL_ISO])
    begin
      pv = !pv;
      dv = !dv;
    end
    s_d.pins = {pv, !pv, dv, !dv};
    // monitor pins through two flops
    s_d.s1 = {link.mon_a_pos_pin, link.mon_b_pos_pin, link.mon_z_pos_pin};
    s_d.s2 = s_q.s1;
    // monitor ignored for 3 s after reset
    if (s_q.wait_cnt != BW'(BLANK_CYCLES))
      s_d.wait_cnt = s_q.wait_cnt + 1'b1;
    s_d.ready = s_q.wait_cnt == BW'(BLANK_CYCLES);
    s_d.midx = quad_idx(s_q.s2[2], s_q.s2[1]);
    s_d.zq = s_q.s2[0];
    if (s_q.ready)
    begin
      s_d.mpos = s_q.mpos + 32'(quad_step(s_q.midx, s_d.midx));
      if (s_q.s2[0] && !s_q.zq)
        s_d.zcnt = s_q.zcnt + 1'b1;
    end
    // read data, unmapped reads as zero
    s_d.rdata = '0;
    if (rd)
    begin
      case (addr)
        `PGF_REG_CTRL: s_d.rdata = {28'h000_0000, s_q.ctrl};
        `PGF_REG_HALF: s_d.rdata = {16'h0000, s_q.half};
        `PGF_REG_MOVE: s_d.rdata = s_q.remain;
        `PGF_REG_STAT: s_d.rdata = {30'h0000_0000, s_q.ready,
                                    s_q.remain != '0};
        `PGF_REG_MPOS: s_d.rdata = s_q.mpos;
        `PGF_REG_ZCNT: s_d.rdata = {16'h0000, s_q.zcnt};
        default: s_d.rdata = '0;
      endcase
    end
  end
  // state register; pulse half period resets to a safe rate
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.half <= `PGF_HALF_RESET;
      s_q.pins <= 4'h5;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign rdata = s_q.rdata;
  assign link.cmd_pulse_pos_pin = s_q.pins[3];
  assign link.cmd_pulse_neg_pin = s_q.pins[2];
  assign link.cmd_dir_pos_pin = s_q.pins[1];
  assign link.cmd_dir_neg_pin = s_q.pins[0];
  assign link.pulse_count_enable = s_q.ctrl[`PGF_CTRL_EN];
  assign link.gear_ratio_select = s_q.ctrl[`PGF_CTRL_SEL];
endmodule // pgf_host
`default_nettype wire

/* File: pgf_chk.sv */
/*
  Checker on the pgf link pins.
  Assumes the signals of one pgf_if and its sys_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module pgf_chk #(
  parameter int BLANK = 20
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cmd_pulse_pos_pin,
  input wire logic cmd_pulse_neg_pin,
  input wire logic mon_a_pos_pin,
  input wire logic mon_a_neg_pin,
  input wire logic mon_b_pos_pin,
  input wire logic mon_b_neg_pin,
  input wire logic mon_z_pos_pin,
  input wire logic mon_z_neg_pin,
  input wire logic monitor_phase_z_out
);
  logic [31:0] cnt_q;
  logic a_off, b_off, z_off;
  // a pair with neither side high is a disabled output
  assign a_off = !mon_a_pos_pin && !mon_a_neg_pin;
  assign b_off = !mon_b_pos_pin && !mon_b_neg_pin;
  assign z_off = !mon_z_pos_pin && !mon_z_neg_pin;
  // cycles since reset release, saturating
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
      cnt_q <= '0;
    else if (cnt_q < BLANK)
      cnt_q <= cnt_q + 1;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_hold;
    $stable(cmd_pulse_pos_pin) [*2];
  endsequence
  property p_a_pair; mon_a_pos_pin |-> !mon_a_neg_pin; endproperty
  property p_b_pair; mon_b_pos_pin |-> !mon_b_neg_pin; endproperty
  property p_z_oc; monitor_phase_z_out == mon_z_pos_pin; endproperty
  property p_blank; cnt_q < BLANK |-> a_off && b_off && z_off; endproperty
  property p_off_all; a_off == b_off && b_off == z_off; endproperty
  property p_stay; !a_off |=> !a_off; endproperty
  property p_gray;
    !a_off && $past(!a_off) |->
      !($changed(mon_a_pos_pin) && $changed(mon_b_pos_pin));
  endproperty
  property p_cmd_pair; cmd_pulse_pos_pin != cmd_pulse_neg_pin; endproperty
  property p_cmd_hold; $changed(cmd_pulse_pos_pin) |=> s_hold; endproperty
  a_a_pair: assert property (p_a_pair) else $error("a pair both on");
  a_b_pair: assert property (p_b_pair) else $error("b pair both on");
  a_z_oc: assert property (p_z_oc) else $error("z open drain differs");
  a_blank: assert property (p_blank) else $error("output in blank");
  a_off_all: assert property (p_off_all) else $error("partly off");
  a_stay: assert property (p_stay) else $error("monitor dropped");
  a_gray: assert property (p_gray) else $error("a and b moved");
  a_cmd_pair: assert property (p_cmd_pair) else $error("cmd pair");
  a_cmd_hold: assert property (p_cmd_hold) else $error("short pulse");
endmodule // pgf_chk
`default_nettype wire

/* File: test_pulse_gear_filter_encoder_monitor.sv */
/*
  Testbench: host and device joined by pgf_if, three reset passes.
  Assumes safe short counts: tick 10, blank 20 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module test_pulse_gear_filter_encoder_monitor;
  import pgf_pkg::*;
  logic sys_clk = 0, resetn = 0, pm = 1, iso = 0, order = 0, sb = 0;
  logic enc_a = 0, enc_b = 0, enc_z = 0, wr = 0, rd = 0, rd_q = 0;
  logic look = 0, flt, mval, grf;
  logic [7:0] addr = 0;
  logic [31:0] wdata = 0, rdata, look_v = 0, g, st = 20899;
  logic [13:0] mul = 0, dvs = 0;
  logic [15:0] na = 1, nb = 2, db = 2;
  pgf_enc_e et = PGF_ENC_SERIAL;
  logic signed [31:0] spd = 0, pos, pos_f, spd_f;
  logic [31:0] q[$];
  int fails = 0, samples_checked = 0, e, r;
  pgf_if lnk();
  pgf_device #(.TICK_CYCLES(10), .BLANK_CYCLES(20)) i_pgf_device (
    .link(lnk), .sys_clk(sys_clk), .resetn(resetn),
    .position_mode(pm), .isolated_logic(iso), .pulse_mode(PGF_PM_PS),
    .gear_num_a(na), .gear_den_a(na), .gear_num_b(nb),
    .gear_den_b(db), .speed_filter_tc(16'h0000),
    .position_filter_tc(16'h0000), .speed_cmd_in(spd),
    .enc_a(enc_a), .enc_b(enc_b), .enc_z(enc_z),
    .encoder_type_select(et), .monitor_multiplier(mul),
    .monitor_divisor(dvs), .monitor_phase_order(order),
    .position_cmd(pos), .position_cmd_filt(pos_f),
    .speed_cmd_filt(spd_f), .gear_ratio_fault(grf),
    .monitor_setting_fault(flt), .monitor_valid(mval));
  pgf_host #(.BLANK_CYCLES(20)) i_pgf_host (.link(lnk),
    .sys_clk(sys_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata));
  pgf_chk #(.BLANK(20)) i_pgf_chk (.sys_clk(sys_clk), .resetn(resetn),
    .cmd_pulse_pos_pin(lnk.cmd_pulse_pos_pin),
    .cmd_pulse_neg_pin(lnk.cmd_pulse_neg_pin),
    .mon_a_pos_pin(lnk.mon_a_pos_pin), .mon_a_neg_pin(lnk.mon_a_neg_pin),
    .mon_b_pos_pin(lnk.mon_b_pos_pin), .mon_b_neg_pin(lnk.mon_b_neg_pin),
    .mon_z_pos_pin(lnk.mon_z_pos_pin), .mon_z_neg_pin(lnk.mon_z_neg_pin),
    .monitor_phase_z_out(lnk.monitor_phase_z_out));
  // 100 MHz clock
  always #5 sys_clk = !sys_clk;
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge sys_clk);
    wr <= 0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] x);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1;
    q.push_back(x);
    @(posedge sys_clk);
    rd <= 0;
  endtask
  task automatic probe(input logic [31:0] v, input logic [31:0] x);
    @(posedge sys_clk);
    look_v <= v;
    look <= 1;
    q.push_back(x);
    @(posedge sys_clk);
    look <= 0;
  endtask
  // one train; c is {position mode, select, enable}
  task automatic mv(input logic [2:0] c);
    int n;
    st = xs(st);
    n = st % 4 + 1;
    wreg(8'h00, {29'h0, iso, c[1:0]});
    pm <= c[2];
    if (c[1] != sb)
      r = 0;
    sb = c[1];
    wreg(8'h08, n);
    tk(40);
    if (c == 3'b101)
      e += n;
    else if (c == 3'b111)
    begin
      r += n * nb;
      e += r / db;
      r %= db;
    end
    probe(pos, e);
  endtask
  // read data arrive a cycle after rd, probe values with look; oldest note first
  always @(posedge sys_clk)
  begin
    rd_q <= rd;
    if (rd_q || look)
    begin
      g = rd_q ? rdata : look_v;
      samples_checked++;
      if (q.size() == 0 || g !== q[0])
      begin
        fails++;
        $display("[FAIL] t=%0t got %h exp %h", $time, g, q[0]);
      end
      void'(q.pop_front());
    end
  end
  task automatic conclude();
    // a note never answered is a missed result
    fails += q.size();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // hang guard, far beyond three passes
  initial
  begin
    #200000;
    fails++;
    conclude();
  end
  initial
  begin
    for (int p = 0; p < 3; p++)
    begin
      // let the last read answer land before reset clears it
      tk(2);
      resetn <= 0;
      iso <= p == 1;
      order <= p == 1;
      // 8192 is the top legal serial multiplier: rate 1/4
      mul <= p == 2 ? 14'd5 : 14'h2000;
      nb <= p + 2;
      db <= 16'(p + 1);
      et <= pgf_enc_e'(p == 2);
      st = xs(st);
      // divisor 8192 kept out so the last pass must fault
      dvs <= p == 2 ? {1'b0, st[12:0]} : st[13:0];
      tk(20);
      resetn <= 1;
      e = 0;
      r = 0;
      sb = 0;
      rreg(8'h0c, 0);
      tk(1);
      probe(mval, 0);
      wreg(8'h04, 2);
      mv(3'b101);
      mv(3'b001);
      mv(3'b111);
      mv(3'b110);
      mv(3'b111);
      tk(1);
      probe(pos_f, e);
      st = xs(st);
      spd <= st;
      tk(3);
      probe(spd_f, spd);
      tk(1);
      probe(flt, p == 2);
      db <= 0;
      tk(1);
      probe(grf, 1);
      rreg(8'h0c, 2);
      for (int i = 0; i < 8; i++)
      begin
        @(posedge sys_clk);
        enc_a <= i % 4 < 2;
        enc_b <= i % 4 == 1 || i % 4 == 2;
        enc_z <= i < 2;
        repeat (4) @(posedge sys_clk);
      end
      tk(10);
      rreg(8'h10, p == 0 ? 2 : p == 1 ? -2 : 0);
      rreg(8'h14, p < 2);
      $display("pass %0d done", p);
    end
    tk(2);
    conclude();
  end
endmodule // test_pulse_gear_filter_encoder_monitor
`default_nettype wire
